// File: cpcb_pkg.sv
/*
 Shared constants of the communication parameter bank: register indices,
 speed word field layout, reset values, rate tables and timing counts.
 Assumes a 10 MHz system clock and 32-bit word-aligned register access.
*/
package cpcb_pkg;

    localparam int CLK_HZ = 10_000_000;

    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_SERIAL = 8'h04;
    localparam logic [7:0] IDX_NODE   = 8'h05;
    localparam logic [7:0] IDX_SPEED  = 8'h06;
    localparam logic [7:0] IDX_INIT   = 8'h10;
    localparam logic [7:0] IDX_SAVE   = 8'h11;
    localparam logic [7:0] IDX_FW     = 8'h12;
    localparam int         IDX_LSB    = 2;
    localparam int         IDX_MSB    = 9;

    localparam logic [7:0]  NODE_MIN  = 8'h01;
    localparam logic [7:0]  NODE_MAX  = 8'h3F;
    localparam logic [7:0]  NODE_DEF  = 8'h3F;
    localparam logic [15:0] SPEED_DEF = 16'h0004;
    localparam logic [15:0] CMD_GO    = 16'h0001;

    // Speed word fields, four bits each
    localparam int         NET_LSB  = 0;
    localparam int         R232_LSB = 4;
    localparam int         R485_LSB = 8;
    localparam int         FMT_LSB  = 12;
    localparam logic [3:0] NET_125K = 4'h0;
    localparam logic [3:0] NET_250K = 4'h1;
    localparam logic [3:0] NET_500K = 4'h2;
    localparam logic [3:0] NET_1M   = 4'h4;
    localparam logic [3:0] BAUD_MAX = 4'h6;
    localparam logic [3:0] FMT_MAX  = 4'h5;
    localparam logic [3:0] FMT_PAR  = 4'h2;
    localparam logic [3:0] FMT_ODD  = 4'h4;

    localparam int NET_RATE_125K = 125_000;
    localparam int NET_RATE_250K = 250_000;
    localparam int NET_RATE_500K = 500_000;
    localparam int NET_RATE_1M   = 1_000_000;
    localparam int BAUD_9600     = 9_600;
    localparam int BAUD_19200    = 19_200;
    localparam int BAUD_38400    = 38_400;
    localparam int BAUD_56000    = 56_000;
    localparam int BAUD_57600    = 57_600;
    localparam int BAUD_115200   = 115_200;

    // Nonvolatile word write time, rounded up to whole cycles
    localparam int         NV_WR_NS   = 500;
    localparam int         NV_WR_CYC  = (NV_WR_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [3:0] NV_TMR_LD  = 4'(NV_WR_CYC - 1);
    localparam int         NV_WORDS   = 2;
    localparam logic       NV_W_NODE  = 1'b0;
    localparam logic       NV_W_SPEED = 1'b1;

    typedef enum logic [1:0] {
        ST_BOOT   = 2'b00,
        ST_IDLE   = 2'b01,
        ST_RELOAD = 2'b10,
        ST_SAVE   = 2'b11
    } cpcb_state_t;

    function automatic logic [3:0] fld(input logic [15:0] w, input int lsb);
        return w[lsb +: 4];
    endfunction

    function automatic logic node_ok(input logic [7:0] n);
        return (n >= NODE_MIN) && (n <= NODE_MAX);
    endfunction

    function automatic logic speed_ok(input logic [15:0] w);
        logic [3:0] n;
        n = fld(w, NET_LSB);
        return ((n == NET_125K) || (n == NET_250K) || (n == NET_500K) || (n == NET_1M))
            && (fld(w, R232_LSB) <= BAUD_MAX) && (fld(w, R485_LSB) <= BAUD_MAX)
            && (fld(w, FMT_LSB) <= FMT_MAX);
    endfunction

endpackage

// File: cpcb_rate.sv
/*
 Active link rate holder: latches the speed word only on a load pulse and
 turns it into bit periods in system clocks and a character format.
 Assumes load is pulsed once after reset, from the boot state.
*/
`timescale 1ns/1ns
module cpcb_rate
    import cpcb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        load,
    input  wire logic [15:0] word,
    output logic      [7:0]  net_cyc,
    output logic      [15:0] r232_cyc,
    output logic      [15:0] r485_cyc,
    output logic             par_en,
    output logic             par_odd,
    output logic             stop_two
);

    function automatic logic [7:0] net_cycles(input logic [3:0] c);
        case (c)
            NET_125K: return 8'(CLK_HZ / NET_RATE_125K);
            NET_250K: return 8'(CLK_HZ / NET_RATE_250K);
            NET_500K: return 8'(CLK_HZ / NET_RATE_500K);
            default:  return 8'(CLK_HZ / NET_RATE_1M);
        endcase
    endfunction

    // Codes 0 and 6 both mean the fastest rate
    function automatic logic [15:0] baud_cycles(input logic [3:0] c);
        case (c)
            4'h1:    return 16'(CLK_HZ / BAUD_9600);
            4'h2:    return 16'(CLK_HZ / BAUD_19200);
            4'h3:    return 16'(CLK_HZ / BAUD_38400);
            4'h4:    return 16'(CLK_HZ / BAUD_56000);
            4'h5:    return 16'(CLK_HZ / BAUD_57600);
            default: return 16'(CLK_HZ / BAUD_115200);
        endcase
    endfunction

    // Only a load changes the rates, so a new word waits for the next boot
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            net_cyc  <= net_cycles(fld(SPEED_DEF, NET_LSB));
            r232_cyc <= baud_cycles(fld(SPEED_DEF, R232_LSB));
            r485_cyc <= baud_cycles(fld(SPEED_DEF, R485_LSB));
            par_en   <= 1'b0;
            par_odd  <= 1'b0;
            stop_two <= 1'b0;
        end else if (load) begin
            net_cyc  <= net_cycles(fld(word, NET_LSB));
            r232_cyc <= baud_cycles(fld(word, R232_LSB));
            r485_cyc <= baud_cycles(fld(word, R485_LSB));
            par_en   <= fld(word, FMT_LSB) >= FMT_PAR;
            par_odd  <= fld(word, FMT_LSB) >= FMT_ODD;
            stop_two <= word[FMT_LSB];
        end
    end

endmodule

// File: cpcb_nv.sv
/*
 Emulated nonvolatile store for the node identifier and the speed word.
 Assumes start is pulsed only while idle; contents are not touched by reset.
*/
`timescale 1ns/1ns
module cpcb_nv
    import cpcb_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        start,
    input  wire logic [7:0]  node_in,
    input  wire logic [15:0] speed_in,
    output logic      [7:0]  node_out,
    output logic      [15:0] speed_out,
    output logic             busy
);

    // Power-up contents of the emulated storage; only a save rewrites them
    logic [15:0] mem  [NV_WORDS] = '{{8'h00, NODE_DEF}, SPEED_DEF};
    logic [15:0] snap [NV_WORDS];
    logic [15:0] snap_in [NV_WORDS];
    logic        wptr;
    logic [3:0]  tmr;

    assign snap_in[NV_W_NODE]  = {8'h00, node_in};
    assign snap_in[NV_W_SPEED] = speed_in;
    assign node_out  = mem[NV_W_NODE][7:0];
    assign speed_out = mem[NV_W_SPEED];

    // Snapshot at start so later edits do not tear a save
    for (genvar i = 0; i < NV_WORDS; i++) begin : g_word
        always_ff @(posedge clk) begin
            if (start && !busy) begin
                snap[i] <= snap_in[i];
            end
            if (busy && (tmr == 4'h0) && (wptr == 1'(i))) begin
                mem[i] <= snap[i];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy <= 1'b0;
            wptr <= 1'b0;
            tmr  <= 4'h0;
        end else if (start && !busy) begin
            busy <= 1'b1;
            wptr <= 1'b0;
            tmr  <= NV_TMR_LD;
        end else if (busy) begin
            if (tmr != 4'h0) begin
                tmr <= tmr - 4'h1;
            end else if (wptr == 1'(NV_WORDS - 1)) begin
                busy <= 1'b0;
            end else begin
                wptr <= wptr + 1'b1;
                tmr  <= NV_TMR_LD;
            end
        end
    end

endmodule

// File: cpcb_top.sv
/*
 Communication parameter bank with an AHB-Lite slave: node identifier,
 speed word, reload and save commands, serial number and firmware code.
 Assumes a single AHB-Lite master, word transfers only, HREADY fed back
 from HREADYOUT.
*/
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ns
// What this block does
// - Node id 1 to 63, default 63
// - Speed bits 3-0 pick network rate
// - Bits 7-4 pick RS232 baud rate
// - Bits 11-8 pick RS485 baud rate
// - Bits 15-12 pick character format
// - New speeds apply only after save, reboot
// - Init command reloads built-in defaults
// - Save command copies parameters to storage
// - Serial number is read only
// - Firmware code is read only
module cpcb_top
    import cpcb_pkg::*;
#(
    parameter logic [31:0] SERIAL_NUMBER = 32'h0000_0001,  // Arbitrary value
    parameter logic [15:0] FIRMWARE_ID   = 16'h0001        // Arbitrary value
) (
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    input  wire logic        HSEL,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HREADY,
    output logic      [31:0] HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    output logic      [7:0]  NODE_ID,
    output logic      [7:0]  NET_BIT_CYCLES,
    output logic      [15:0] RS232_BIT_CYCLES,
    output logic      [15:0] RS485_BIT_CYCLES,
    output logic             PARITY_EN,
    output logic             PARITY_ODD,
    output logic             STOP_TWO
);

    cpcb_state_t state;
    logic [7:0]  node;
    logic [15:0] speed;
    logic        init_cmd;
    logic        save_cmd;
    logic        rd_ph;
    logic        wr_ph;
    logic [7:0]  ph_idx;
    logic [31:0] rdata;
    logic        nv_busy;
    logic [7:0]  nv_node;
    logic [15:0] nv_speed;
    logic        addr_ok;
    logic        idle;
    logic        wr_node_ok;
    logic        wr_speed_ok;
    logic        wr_init;
    logic        wr_save;

    assign addr_ok = HSEL && HTRANS[1] && HREADY;
    assign idle    = (state == ST_IDLE);
    assign NODE_ID = node;

    // Parameter writes only land while no command runs
    assign wr_node_ok  = wr_ph && idle && (ph_idx == IDX_NODE) && node_ok(HWDATA[7:0]);
    assign wr_speed_ok = wr_ph && idle && (ph_idx == IDX_SPEED) && speed_ok(HWDATA[15:0]);
    assign wr_init     = wr_ph && idle && (ph_idx == IDX_INIT) && (HWDATA[15:0] == CMD_GO);
    assign wr_save     = wr_ph && idle && (ph_idx == IDX_SAVE) && (HWDATA[7:0] == CMD_GO[7:0]);

    // Address phase capture; reads take one wait state so a write just
    // before is always seen
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            rd_ph  <= 1'b0;
            wr_ph  <= 1'b0;
            ph_idx <= 8'h00;
        end else begin
            rd_ph <= addr_ok && !HWRITE;
            wr_ph <= addr_ok && HWRITE;
            if (addr_ok) begin
                ph_idx <= HADDR[IDX_MSB:IDX_LSB];
            end
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        case (ph_idx)
            IDX_SERIAL: rdata = SERIAL_NUMBER;
            IDX_NODE:   rdata[7:0] = node;
            IDX_SPEED:  rdata[15:0] = speed;
            IDX_INIT:   rdata[0] = init_cmd;
            IDX_SAVE:   rdata[0] = save_cmd;
            IDX_FW:     rdata[15:0] = FIRMWARE_ID;
            default:    rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            HREADYOUT <= !(addr_ok && !HWRITE);
            if (rd_ph) begin
                HRDATA <= rdata;
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state <= ST_BOOT;
        end else begin
            case (state)
                ST_BOOT: begin
                    state <= ST_IDLE;
                end
                ST_IDLE: begin
                    if (wr_init) begin
                        state <= ST_RELOAD;
                    end else if (wr_save) begin
                        state <= ST_SAVE;
                    end
                end
                ST_RELOAD: begin
                    state <= ST_IDLE;
                end
                ST_SAVE: begin
                    if (!nv_busy) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_BOOT;
                end
            endcase
        end
    end

    // Stored values are checked again at boot, so a bad store cannot
    // leave the node with an illegal identifier
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            node  <= NODE_DEF;
            speed <= SPEED_DEF;
        end else if (state == ST_BOOT) begin
            node  <= node_ok(nv_node) ? nv_node : NODE_DEF;
            speed <= speed_ok(nv_speed) ? nv_speed : SPEED_DEF;
        end else if (state == ST_RELOAD) begin
            node  <= NODE_DEF;
            speed <= SPEED_DEF;
        end else begin
            if (wr_node_ok) begin
                node <= HWDATA[7:0];
            end
            if (wr_speed_ok) begin
                speed <= HWDATA[15:0];
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            init_cmd <= 1'b0;
        end else if (wr_init) begin
            init_cmd <= 1'b1;
        end else if (state == ST_RELOAD) begin
            init_cmd <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            save_cmd <= 1'b0;
        end else if (wr_save) begin
            save_cmd <= 1'b1;
        end else if ((state == ST_SAVE) && !nv_busy) begin
            save_cmd <= 1'b0;
        end
    end

    cpcb_nv u_nv (
        .clk       (CLK),
        .rst       (SYS_RST),
        .start     (wr_save),
        .node_in   (node),
        .speed_in  (speed),
        .node_out  (nv_node),
        .speed_out (nv_speed),
        .busy      (nv_busy)
    );

    // Active rates load from storage only at boot
    cpcb_rate u_rate (
        .clk      (CLK),
        .rst      (SYS_RST),
        .load     (state == ST_BOOT),
        .word     (nv_speed),
        .net_cyc  (NET_BIT_CYCLES),
        .r232_cyc (RS232_BIT_CYCLES),
        .r485_cyc (RS485_BIT_CYCLES),
        .par_en   (PARITY_EN),
        .par_odd  (PARITY_ODD),
        .stop_two (STOP_TWO)
    );

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    localparam int SAVE_MAX = 12;

    chk_node_range: assert property (node_ok(node))
        else $error("node identifier out of range");

    chk_node_reject: assert property (
        wr_ph && (ph_idx == IDX_NODE) && !node_ok(HWDATA[7:0]) |=> $stable(node))
        else $error("illegal node identifier accepted");

    chk_net_code: assert property (
        (fld(speed, NET_LSB) == NET_125K) || (fld(speed, NET_LSB) == NET_250K)
        || (fld(speed, NET_LSB) == NET_500K) || (fld(speed, NET_LSB) == NET_1M))
        else $error("bad network rate code held");

    chk_baud_codes: assert property (
        (fld(speed, R232_LSB) <= BAUD_MAX) && (fld(speed, R485_LSB) <= BAUD_MAX))
        else $error("bad serial baud code held");

    chk_fmt_code: assert property (fld(speed, FMT_LSB) <= FMT_MAX)
        else $error("bad character format code held");

    chk_active_hold: assert property (
        (state != ST_BOOT) |=> $stable(NET_BIT_CYCLES) && $stable(RS232_BIT_CYCLES) && $stable(RS485_BIT_CYCLES))
        else $error("active rates changed outside boot");

    chk_reload_values: assert property (
        wr_init |=> (state == ST_RELOAD) ##1 (node == NODE_DEF && speed == SPEED_DEF && !init_cmd))
        else $error("reload did not restore defaults");

    chk_save_done: assert property (
        wr_save |=> save_cmd && nv_busy ##[1:SAVE_MAX] (state == ST_IDLE && !save_cmd))
        else $error("save did not finish in time");

    chk_serial_read: assert property (
        rd_ph && (ph_idx == IDX_SERIAL) |=> HRDATA == SERIAL_NUMBER && HREADYOUT)
        else $error("serial number read wrong");

    chk_fw_read: assert property (
        rd_ph && (ph_idx == IDX_FW) |=> HRDATA == {16'h0000, FIRMWARE_ID})
        else $error("firmware code read wrong");

    chk_cmd_clear: assert property (
        (state == ST_SAVE) && !nv_busy |=> !save_cmd && idle)
        else $error("save command not cleared");

    chk_node_write: assert property (
        wr_node_ok |=> NODE_ID == $past(HWDATA[7:0]))
        else $error("legal node identifier not taken");

    chk_speed_reject: assert property (
        wr_ph && idle && (ph_idx == IDX_SPEED) && !speed_ok(HWDATA[15:0]) |=> $stable(speed))
        else $error("illegal speed word accepted");

    chk_init_refuse: assert property (
        wr_ph && idle && (ph_idx == IDX_INIT) && (HWDATA[15:0] != CMD_GO) |=> idle && !init_cmd)
        else $error("reload started by a value other than one");

    chk_reload_state: assert property (
        (state == ST_RELOAD) |=> idle)
        else $error("reload lasted more than one cycle");

    chk_save_start: assert property (
        wr_save |=> (state == ST_SAVE))
        else $error("save command did not start a save");

    chk_save_lock: assert property (
        (state == ST_SAVE) |=> $stable(node) && $stable(speed))
        else $error("parameter changed while saving");

    chk_save_image: assert property (
        (state == ST_SAVE) && !nv_busy |-> (nv_node == node) && (nv_speed == speed))
        else $error("stored image differs from parameters");

    chk_cmd_idle: assert property (
        idle |-> !init_cmd && !save_cmd)
        else $error("command reads one while idle");

    // Commands only start from idle, so idle with a command set is a stuck flag
    cov_reload: cover property (wr_init ##2 idle);
    cov_save: cover property (wr_save ##[1:SAVE_MAX] (idle && !save_cmd));
    cov_speed_write: cover property (wr_speed_ok);
    cov_read_wait: cover property (rd_ph && !HREADYOUT);

endmodule

// File: cpcb_ahb_master.sv
/*
 Behavioural AHB-Lite master that stands for the network or host master.
 Assumes one slave whose HREADYOUT is fed back as HREADY, word transfers only.
*/
`timescale 1ns/1ns
module cpcb_ahb_master (
    input  wire logic        clk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic      [31:0] haddr,
    output logic      [1:0]  htrans,
    output logic             hwrite,
    output logic      [2:0]  hsize,
    output logic      [31:0] hwdata
);
    // Idle bus at time zero; data lines start at a pattern, not zero
    initial begin
        hsel   = 1'b0;
        haddr  = 32'h0000_0000;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize  = 3'b010;
        hwdata = 32'hDEAD_BEEF;
    end

    // Address phase held until HREADY is seen high, then data phase likewise
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wr ? d : ~hwdata;
        do @(posedge clk); while (hready !== 1'b1);
        q = hrdata;
        // Released data line no longer shows the last value
        hwdata <= ~hwdata;
    endtask

    task automatic write(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask

    task automatic read(input logic [31:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0000_0000, q);
    endtask
endmodule

// File: tb_cpcb_top.sv
/*
 Self-checking testbench of the communication parameter bank.
 Assumes the bus master model above and the register map of the package.
*/
`timescale 1ns/1ns
module tb_cpcb_top
    import cpcb_pkg::*;
;
    localparam logic [31:0] SN = 32'h1234_5678;  // Arbitrary value
    localparam logic [15:0] FW = 16'hA5C3;       // Arbitrary value
    localparam logic [31:0] A_SN = 32'h10, A_ND = 32'h14, A_SP = 32'h18;
    localparam logic [31:0] A_IN = 32'h40, A_SV = 32'h44, A_FW = 32'h48;

    logic        clk;
    logic        sys_rst;
    logic        hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [7:0]  node_id, net_cyc;
    logic [15:0] r232_cyc, r485_cyc;
    logic        par_en, par_odd, stop_two;
    int          err_count;
    int          n_tests;
    int          cyc;

    cpcb_ahb_master u_mst (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    cpcb_top #(.SERIAL_NUMBER(SN), .FIRMWARE_ID(FW)) u_dut (.CLK(clk), .SYS_RST(sys_rst),
        .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
        .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
        .HRESP(hresp), .NODE_ID(node_id), .NET_BIT_CYCLES(net_cyc),
        .RS232_BIT_CYCLES(r232_cyc), .RS485_BIT_CYCLES(r485_cyc), .PARITY_EN(par_en),
        .PARITY_ODD(par_odd), .STOP_TWO(stop_two));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic tally_and_finish();
        if (err_count == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Hang guard, well above the length of all scenarios
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
        logic [31:0] q;
        u_mst.read(a, q);
        check(q, exp);
    endtask

    task automatic pulse_reset();
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    // Poll a command word until it reads back zero, bounded
    task automatic wait_cmd(input logic [31:0] a);
        logic [31:0] q;
        int          i;
        q = 32'h1;
        for (i = 0; i < 40 && q !== 32'h0; i++) begin
            u_mst.read(a, q);
        end
        check(q, 32'h0);
    endtask

    task automatic t_reset_values();
        rd_chk(A_ND, 32'h3F);
        rd_chk(A_SP, 32'h4);
        rd_chk(A_IN, 32'h0);
        rd_chk(A_SV, 32'h0);
        rd_chk(A_SN, SN);
        rd_chk(A_FW, {16'h0, FW});
        check(net_cyc, 8'd10);
        check({r232_cyc, r485_cyc}, {16'd86, 16'd86});
        check({par_en, par_odd, stop_two, hresp}, 4'h0);
    endtask

    task automatic t_node_range();
        // Each node on one network gets its own identifier
        u_mst.write(A_ND, 32'h0);
        rd_chk(A_ND, 32'h3F);
        u_mst.write(A_ND, 32'h1);
        rd_chk(A_ND, 32'h1);
        check(node_id, 8'h01);
        u_mst.write(A_ND, 32'h40);
        rd_chk(A_ND, 32'h1);
        u_mst.write(A_ND, 32'h3F);
        rd_chk(A_ND, 32'h3F);
    endtask

    task automatic t_read_only();
        u_mst.write(A_SN, 32'h0);
        u_mst.write(A_FW, 32'h0);
        rd_chk(A_SN, SN);
        rd_chk(A_FW, {16'h0, FW});
        rd_chk(32'h3C, 32'h0);
    endtask

    task automatic t_speed_refused();
        logic [15:0] bad [4] = '{16'h0003, 16'h0074, 16'h0704, 16'h6004};
        foreach (bad[i]) begin
            u_mst.write(A_SP, {16'h0, bad[i]});
            rd_chk(A_SP, 32'h4);
        end
        u_mst.write(A_SP, 32'h5664);
        rd_chk(A_SP, 32'h5664);
        u_mst.write(A_IN, 32'h2);
        rd_chk(A_IN, 32'h0);
        check({net_cyc, r232_cyc}, {8'd10, 16'd86});
        check({par_en, par_odd, stop_two}, 3'h0);
    endtask

    // Save, power cycle and look at the active rates for a table of words
    task automatic t_save_reboot();
        logic [7:0]  netc [4] = '{8'd80, 8'd40, 8'd20, 8'd10};
        logic [15:0] baud [7] = '{16'd86, 16'd1041, 16'd520, 16'd260, 16'd178, 16'd173, 16'd86};
        logic [3:0]  netk [4] = '{4'h0, 4'h1, 4'h2, 4'h4};
        logic [2:0]  fmtx [6] = '{3'b000, 3'b001, 3'b100, 3'b101, 3'b110, 3'b111};
        logic [3:0]  f;
        logic [31:0] q;
        int          i;
        for (i = 0; i < 7; i++) begin
            f = 4'(i % 6);
            u_mst.write(A_SP, {16'h0, f, 4'(6 - i), 4'(i), netk[i % 4]});
            u_mst.write(A_SV, 32'h1);
            u_mst.read(A_SV, q);
            check(q, 32'h1);
            u_mst.write(A_ND, 32'h9);
            wait_cmd(A_SV);
            rd_chk(A_ND, 32'h3F);
            check(net_cyc, 8'd10);
            pulse_reset();
            check(net_cyc, netc[i % 4]);
            check({r232_cyc, r485_cyc}, {baud[i], baud[6 - i]});
            check({par_en, par_odd, stop_two}, fmtx[f]);
            rd_chk(A_ND, 32'h3F);
            u_mst.write(A_SP, 32'h4);
            u_mst.write(A_SV, 32'h1);
            wait_cmd(A_SV);
            pulse_reset();
        end
    endtask

    task automatic t_reload();
        u_mst.write(A_ND, 32'h5);
        u_mst.write(A_SP, 32'h0021);
        rd_chk(A_SP, 32'h0021);
        u_mst.write(A_IN, 32'h1);
        wait_cmd(A_IN);
        rd_chk(A_ND, 32'h3F);
        rd_chk(A_SP, 32'h4);
        check(node_id, 8'h3F);
    endtask

    initial begin
        err_count = 0;
        n_tests   = 0;
        cyc       = 0;
        sys_rst   = 1'b1;
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_reset_values();
        t_node_range();
        t_read_only();
        t_speed_refused();
        pulse_reset();
        t_save_reboot();
        t_reload();
        tally_and_finish();
    end
endmodule
